// ---- rtl/irq_event_router_pkg.sv ----
package irq_event_router_pkg;

    // register byte offsets; no offsets are printed, these are local
    localparam logic [7:0] OFF_IRQ_SEL_B = 8'h00;
    localparam logic [7:0] OFF_IRQ_SEL_C = 8'h04;
    localparam logic [7:0] OFF_EVT_SEL = 8'h08;
    localparam logic [7:0] OFF_MEM_PRIO = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

    localparam int SEL_W = 5;
    localparam int FIELD_STRIDE = 8;
    localparam int NUM_SRC = 32;
    localparam int NUM_IRQ_B = 4;
    localparam int NUM_EVT = 4;
    localparam int NUM_OUT = 9;

    // writable bits of each register; all others read as zero
    localparam logic [31:0] SEL_FOUR_MASK = 32'h1F1F1F1F;
    localparam logic [31:0] SEL_ONE_MASK = 32'h0000001F;
    localparam logic [31:0] PRIO_MASK = 32'h011FFFFE;
    localparam logic [31:0] STAT_MASK = 32'h00001FFF;

    localparam int PRIO_COPY_BIT = 24;
    localparam int PRIO_LO_BIT = 1;
    localparam int PRIO_HI_BIT = 20;

    localparam logic [31:0] REG_RESET = 32'h00000000;

    // bit n is set where source code n carries a real source
    localparam logic [31:0] SRC_VALID_MASK = 32'h3FF36FBF;

endpackage

// ---- rtl/source_select.sv ----
`timescale 1ns/100ps
`default_nettype none
module source_select
    import irq_event_router_pkg::*;
(
    // sources and selection
    input wire logic [NUM_SRC-1:0] sources,
    input wire logic [SEL_W-1:0] sel,
    // routed level
    output logic routed
);
    // reserved codes gate the output low instead of passing a dead input
    wire logic codeValid = SRC_VALID_MASK[sel];
    assign routed = codeValid & sources[sel];
endmodule
`default_nettype wire

// ---- rtl/wb_reg_slave.sv ----
`timescale 1ns/100ps
`default_nettype none
module wb_reg_slave
    import irq_event_router_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic wb_err_o,
    // decoded write
    output logic wrEn,
    output logic [31:0] wrMask,
    output logic mapped
);
    wire logic req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign mapped = (wb_adr_i == OFF_IRQ_SEL_B) | (wb_adr_i == OFF_IRQ_SEL_C) |
        (wb_adr_i == OFF_EVT_SEL) | (wb_adr_i == OFF_MEM_PRIO) |
        (wb_adr_i == OFF_IRQ_STATUS) | (wb_adr_i == OFF_IRQ_MASK);
    // write lands on the same edge the ack is raised
    assign wrEn = req & wb_we_i & mapped;
    assign wrMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            wb_ack_o <= req & mapped;
            wb_err_o <= req & ~mapped;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/imaging_irq_event_router.sv ----
// The implementer's own choices: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module imaging_irq_event_router
    import irq_event_router_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // imaging sources, same clock
    input wire logic [NUM_SRC-1:0] sources,
    // routed outputs
    output logic [NUM_IRQ_B-1:0] irqHigh,
    output logic irqLast,
    output logic [NUM_EVT-1:0] evtOut,
    // table memory control
    output logic rgbTableCopyEn,
    output logic [PRIO_HI_BIT:PRIO_LO_BIT] tablePrio,
    // block interrupt
    output logic irqOut
);
    logic [31:0] irqSelB_q;
    logic [31:0] irqSelC_q;
    logic [31:0] event_route_sel_q;
    logic [31:0] memPrio_q;
    logic [31:0] status_q;
    logic [31:0] mask_q;
    logic [NUM_OUT-1:0] routed_q;
    wire logic [NUM_OUT-1:0] routedD;
    logic [NUM_IRQ_B-1:0] irqHighD;
    logic [NUM_EVT-1:0] evtD;
    logic irqLastD;
    logic wrEn;
    logic [31:0] wrMask;
    logic mapped;

    wb_reg_slave u_bus (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_ack_o(wb_ack_o),
        .wb_err_o(wb_err_o),
        .wrEn(wrEn),
        .wrMask(wrMask),
        .mapped(mapped)
    );

    wire logic wrSelB = wrEn & (wb_adr_i == OFF_IRQ_SEL_B);
    wire logic wrSelC = wrEn & (wb_adr_i == OFF_IRQ_SEL_C);
    wire logic wrEvt = wrEn & (wb_adr_i == OFF_EVT_SEL);
    wire logic wrPrio = wrEn & (wb_adr_i == OFF_MEM_PRIO);
    wire logic wrStat = wrEn & (wb_adr_i == OFF_IRQ_STATUS);
    wire logic wrMaskReg = wrEn & (wb_adr_i == OFF_IRQ_MASK);

    // reserved bits are dropped at write time so they can never read back
    wire logic [31:0] nextSelB = (irqSelB_q & ~wrMask) | (wb_dat_i & wrMask & SEL_FOUR_MASK);
    wire logic [31:0] nextSelC = (irqSelC_q & ~wrMask) | (wb_dat_i & wrMask & SEL_ONE_MASK);
    wire logic [31:0] nextEvt = (event_route_sel_q & ~wrMask) | (wb_dat_i & wrMask & SEL_FOUR_MASK);
    wire logic [31:0] nextPrio = (memPrio_q & ~wrMask) | (wb_dat_i & wrMask & PRIO_MASK);
    wire logic [31:0] nextMask = (mask_q & ~wrMask) | (wb_dat_i & wrMask & STAT_MASK);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irqSelB_q <= REG_RESET;
            irqSelC_q <= REG_RESET;
            event_route_sel_q <= REG_RESET;
            memPrio_q <= REG_RESET;
            mask_q <= REG_RESET;
        end else begin
            if (wrSelB) irqSelB_q <= nextSelB;
            if (wrSelC) irqSelC_q <= nextSelC;
            if (wrEvt) event_route_sel_q <= nextEvt;
            if (wrPrio) memPrio_q <= nextPrio;
            if (wrMaskReg) mask_q <= nextMask;
        end
    end

    property p_resv_c;
        @(posedge clk_sys) disable iff (!rstn)
        irqSelC_q[31:5] == 27'h0000000;
    endproperty
    a_resv_c: assert property (p_resv_c)
        else $error("reserved bits of third selection register set");

    property p_prio0;
        @(posedge clk_sys) disable iff (!rstn)
        memPrio_q[0] == 1'b0 && memPrio_q[23:21] == 3'h0;
    endproperty
    a_prio0: assert property (p_prio0)
        else $error("reserved priority bits set");

    property p_resv_sel;
        @(posedge clk_sys) disable iff (!rstn)
        (irqSelB_q & ~SEL_FOUR_MASK) == 32'h0 && (event_route_sel_q & ~SEL_FOUR_MASK) == 32'h0;
    endproperty
    a_resv_sel: assert property (p_resv_sel)
        else $error("reserved selection bits stored");

    // one selector per output; outputs 0-3 irq, 4 last irq, 5-8 events
    genvar g;
    generate
        for (g = 0; g < NUM_OUT; g++) begin : g_route
            logic [SEL_W-1:0] fieldSel;
            if (g < NUM_IRQ_B) begin : g_b
                assign fieldSel = irqSelB_q[g*FIELD_STRIDE +: SEL_W];
            end else if (g == NUM_IRQ_B) begin : g_c
                assign fieldSel = irqSelC_q[SEL_W-1:0];
            end else begin : g_e
                assign fieldSel = event_route_sel_q[(g-NUM_IRQ_B-1)*FIELD_STRIDE +: SEL_W];
            end
            source_select u_sel (
                .sources(sources),
                .sel(fieldSel),
                .routed(routedD[g])
            );
        end
    endgenerate

    assign irqHighD = routedD[NUM_IRQ_B-1:0];
    assign irqLastD = routedD[NUM_IRQ_B];
    assign evtD = routedD[NUM_OUT-1:NUM_IRQ_B+1];

    property p_route_b;
        @(posedge clk_sys) disable iff (!rstn)
        irqHigh[0] == $past(SRC_VALID_MASK[irqSelB_q[4:0]] & sources[irqSelB_q[4:0]]);
    endproperty
    a_route_b: assert property (p_route_b)
        else $error("irq output 4 not following its field");

    property p_route_b5;
        @(posedge clk_sys) disable iff (!rstn)
        irqHigh[1] == $past(SRC_VALID_MASK[irqSelB_q[12:8]] & sources[irqSelB_q[12:8]]);
    endproperty
    a_route_b5: assert property (p_route_b5)
        else $error("irq output 5 not following its field");

    property p_route_b6;
        @(posedge clk_sys) disable iff (!rstn)
        irqHigh[2] == $past(SRC_VALID_MASK[irqSelB_q[20:16]] & sources[irqSelB_q[20:16]]);
    endproperty
    a_route_b6: assert property (p_route_b6)
        else $error("irq output 6 not following its field");

    property p_route_b7;
        @(posedge clk_sys) disable iff (!rstn)
        irqHigh[3] == $past(SRC_VALID_MASK[irqSelB_q[28:24]] & sources[irqSelB_q[28:24]]);
    endproperty
    a_route_b7: assert property (p_route_b7)
        else $error("irq output 7 not following its field");

    property p_route_c;
        @(posedge clk_sys) disable iff (!rstn)
        irqLast == $past(SRC_VALID_MASK[irqSelC_q[4:0]] & sources[irqSelC_q[4:0]]);
    endproperty
    a_route_c: assert property (p_route_c)
        else $error("irq output 8 not following its field");

    property p_evt0;
        @(posedge clk_sys) disable iff (!rstn)
        evtOut[0] == $past(SRC_VALID_MASK[event_route_sel_q[4:0]] & sources[event_route_sel_q[4:0]]);
    endproperty
    a_evt0: assert property (p_evt0)
        else $error("event output 0 wrong");

    property p_evt1;
        @(posedge clk_sys) disable iff (!rstn)
        evtOut[1] == $past(SRC_VALID_MASK[event_route_sel_q[12:8]] & sources[event_route_sel_q[12:8]]);
    endproperty
    a_evt1: assert property (p_evt1)
        else $error("event output 1 wrong");

    property p_evt2;
        @(posedge clk_sys) disable iff (!rstn)
        evtOut[2] == $past(SRC_VALID_MASK[event_route_sel_q[20:16]] & sources[event_route_sel_q[20:16]]);
    endproperty
    a_evt2: assert property (p_evt2)
        else $error("event output 2 wrong");

    property p_evt3;
        @(posedge clk_sys) disable iff (!rstn)
        evtOut[3] == $past(SRC_VALID_MASK[event_route_sel_q[28:24]] & sources[event_route_sel_q[28:24]]);
    endproperty
    a_evt3: assert property (p_evt3)
        else $error("event output 3 wrong");

    property p_evt3_resv;
        @(posedge clk_sys) disable iff (!rstn)
        ($past(event_route_sel_q[28:24]) == 5'h0C) |-> !evtOut[3];
    endproperty
    a_evt3_resv: assert property (p_evt3_resv)
        else $error("event output 3 active on reserved code");

    property p_resv_route;
        @(posedge clk_sys) disable iff (!rstn)
        ($past(irqSelC_q[4:0]) inside {5'h06, 5'h0C, 5'h0F, 5'h12, 5'h13, 5'h1E, 5'h1F})
            |-> !irqLast;
    endproperty
    a_resv_route: assert property (p_resv_route)
        else $error("irq output 8 active on an empty code");

    // registered outputs cost one cycle of latency versus the source
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irqHigh <= '0;
            irqLast <= 1'b0;
            evtOut <= '0;
            routed_q <= '0;
        end else begin
            irqHigh <= irqHighD;
            irqLast <= irqLastD;
            evtOut <= evtD;
            routed_q <= routedD;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rgbTableCopyEn <= 1'b0;
            tablePrio <= '0;
        end else begin
            rgbTableCopyEn <= memPrio_q[PRIO_COPY_BIT];
            tablePrio <= memPrio_q[PRIO_HI_BIT:PRIO_LO_BIT];
        end
    end

    property p_copy;
        @(posedge clk_sys) disable iff (!rstn)
        wrPrio && wrMask[24] |-> ##2 rgbTableCopyEn == $past(wb_dat_i[24], 2);
    endproperty
    a_copy: assert property (p_copy)
        else $error("rgb copy enable not following write");

    property p_copy_out;
        @(posedge clk_sys) disable iff (!rstn)
        rgbTableCopyEn == $past(memPrio_q[24]);
    endproperty
    a_copy_out: assert property (p_copy_out)
        else $error("rgb copy enable not following its bit");

    property p_prio_out;
        @(posedge clk_sys) disable iff (!rstn)
        tablePrio == $past(memPrio_q[20:1]);
    endproperty
    a_prio_out: assert property (p_prio_out)
        else $error("table priority outputs not following their bits");

    // sticky status: rising edge of each routed output; set beats clear
    wire logic [NUM_OUT-1:0] riseEv = routedD & ~routed_q;
    wire logic [31:0] riseWide = {{(32-NUM_OUT){1'b0}}, riseEv};
    wire logic [31:0] clrBits = wrStat ? (wb_dat_i & wrMask) : 32'h00000000;
    wire logic [31:0] statusD = ((status_q & ~clrBits) | riseWide) & STAT_MASK;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            status_q <= REG_RESET;
            irqOut <= 1'b0;
        end else begin
            status_q <= statusD;
            irqOut <= |(statusD & mask_q);
        end
    end

    property p_irq;
        @(posedge clk_sys) disable iff (!rstn)
        irqOut == |($past(statusD) & $past(mask_q));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt output mismatch");

    property p_status_set;
        @(posedge clk_sys) disable iff (!rstn)
        ({evtOut, irqLast, irqHigh} & ~$past({evtOut, irqLast, irqHigh}) & ~status_q[8:0]) == '0;
    endproperty
    a_status_set: assert property (p_status_set)
        else $error("routed rise not latched in status");

    // read mux; reserved bits are already zero in storage
    wire logic [31:0] rdData =
        (wb_adr_i == OFF_IRQ_SEL_B) ? irqSelB_q :
        (wb_adr_i == OFF_IRQ_SEL_C) ? irqSelC_q :
        (wb_adr_i == OFF_EVT_SEL) ? event_route_sel_q :
        (wb_adr_i == OFF_MEM_PRIO) ? memPrio_q :
        (wb_adr_i == OFF_IRQ_STATUS) ? status_q :
        (wb_adr_i == OFF_IRQ_MASK) ? mask_q : 32'h00000000;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wb_dat_o <= 32'h00000000;
        end else if (wb_cyc_i & wb_stb_i & ~wb_we_i & mapped) begin
            wb_dat_o <= rdData;
        end
    end

    property p_ack_pulse;
        @(posedge clk_sys) disable iff (!rstn)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("bus ack held longer than one cycle");

    property p_ack_req;
        @(posedge clk_sys) disable iff (!rstn)
        (wb_ack_o || wb_err_o) |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ack_req: assert property (p_ack_req)
        else $error("bus answer without a request");

    property p_rdata_c;
        @(posedge clk_sys) disable iff (!rstn)
        (wb_ack_o && !wb_we_i && wb_adr_i == OFF_IRQ_SEL_C) |-> wb_dat_o[31:5] == 27'h0000000;
    endproperty
    a_rdata_c: assert property (p_rdata_c)
        else $error("reserved bits of third selection register read as one");
endmodule
`default_nettype wire

// ---- verif/imaging_source_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module imaging_source_model
    import irq_event_router_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // requested and driven levels
    input wire logic [NUM_SRC-1:0] levelReq,
    output logic [NUM_SRC-1:0] sources
);
    // sources share the router clock, so they may only move just after an edge
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sources <= '0;
        end else begin
            sources <= levelReq;
        end
    end
endmodule
`default_nettype wire

// ---- verif/imaging_irq_event_router_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module imaging_irq_event_router_test import irq_event_router_pkg::*;;
    logic clk_sys, rstn, req, we, ack, err, irqLast, copyEn, irqOut;
    logic [7:0] adr;
    logic [31:0] wdat, datO, levelReq, sources, rng, sb, se;
    logic [3:0] irqHigh, evtOut, lane;
    logic [20:1] prio;
    logic [33:0] ent;
    logic [33:0] expQ[$];
    logic [7:0] offs[4] = '{OFF_IRQ_SEL_B, OFF_IRQ_SEL_C, OFF_EVT_SEL, OFF_MEM_PRIO};
    logic [31:0] msks[4] = '{SEL_FOUR_MASK, SEL_ONE_MASK, SEL_FOUR_MASK, PRIO_MASK};
    int nMismatch, nChecks;

    imaging_irq_event_router u_dut (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(req),
        .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(lane), .wb_dat_i(wdat),
        .wb_dat_o(datO), .wb_ack_o(ack), .wb_err_o(err), .sources(sources),
        .irqHigh(irqHigh), .irqLast(irqLast), .evtOut(evtOut), .rgbTableCopyEn(copyEn),
        .tablePrio(prio), .irqOut(irqOut));
    imaging_source_model u_src (.clk_sys(clk_sys), .rstn(rstn), .levelReq(levelReq),
        .sources(sources));

    task automatic fail(input string m);
        nMismatch++;
        $display("mismatch at %0t: %s", $time, m);
    endtask
    task automatic chkBus(input logic [31:0] g, input logic [31:0] e, input string m);
        nChecks++;
        if (g !== e) fail(m);
    endtask
    task automatic chkOut(input logic [31:0] g, input logic [31:0] e, input string m);
        nChecks++;
        if (g !== e) fail(m);
    endtask
    task automatic testDone;
        $display("checks %0d mismatches %0d", nChecks, nMismatch);
        if (nMismatch == 0 && nChecks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    // empty codes give a quiet line rather than a stale source
    function automatic logic lvl(input logic [31:0] s, input int c);
        if (c > 29 || c == 6 || c == 12 || c == 15 || c == 18 || c == 19) return 1'b0;
        return s[c];
    endfunction
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // no local limit: a missing answer is caught by the watchdog
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] l, input logic [33:0] e);
        expQ.push_back(e);
        req <= 1'b1;
        we <= w;
        adr <= a;
        lane <= l;
        wdat <= d;
        do begin
            @(posedge clk_sys);
        end while (ack !== 1'b1 && err !== 1'b1);
        req <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF, 34'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0, 4'hF, {2'b01, x});
    endtask
    task automatic route(input logic [31:0] s, input int c);
        logic [8:0] e;
        for (int i = 0; i < 9; i++) e[i] = lvl(s, (c + i) % 32);
        levelReq <= s;
        idle(3);
        chkOut({23'h0, evtOut, irqLast, irqHigh}, {23'h0, e}, "routed");
    endtask

    always @(posedge clk_sys) begin
        if (ack === 1'b1 || err === 1'b1) begin
            ent = expQ.pop_front();
            chkBus({31'h0, err}, {31'h0, ent[33]}, "answer kind");
            if (ent[32]) chkBus(datO, ent[31:0], "read data");
        end
    end
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        idle(20000);
        fail("watchdog");
        testDone();
    end
    initial begin
        rstn = 1'b0;
        req = 1'b0;
        we = 1'b0;
        lane = 4'hF;
        adr = 8'h00;
        wdat = 32'h0;
        levelReq = 32'h0;
        rng = 32'h0000BCE6;
        idle(16);
        rstn <= 1'b1;
        idle(1);
        chkOut({1'b0, prio, irqOut, copyEn, evtOut, irqLast, irqHigh}, 32'h0, "reset");
        foreach (offs[i]) rd(offs[i], REG_RESET);
        $display("test reset done");
        foreach (offs[i]) begin
            wr(offs[i], 32'hFFFFFFFF);
            rd(offs[i], msks[i]);
        end
        chkOut({11'h0, copyEn, prio}, 32'h001FFFFF, "priority ones");
        rng = xs(rng);
        wr(OFF_MEM_PRIO, rng & PRIO_MASK);
        chkOut({11'h0, copyEn, prio}, {11'h0, rng[24], rng[20:1]}, "priority");
        bus(1'b0, 8'h20, 32'h0, 4'hF, {2'b10, 32'h0});
        bus(1'b1, OFF_EVT_SEL, 32'h03030303, 4'h2, 34'h0);
        rd(OFF_EVT_SEL, 32'h1F1F031F);
        $display("test registers done");
        for (int c = 0; c < 32; c++) begin
            sb = 32'h0;
            se = 32'h0;
            for (int f = 0; f < 4; f++) begin
                sb[8*f +: 5] = 5'((c + f) % 32);
                se[8*f +: 5] = 5'((c + 5 + f) % 32);
            end
            wr(OFF_IRQ_SEL_B, sb);
            wr(OFF_IRQ_SEL_C, {27'h0, 5'((c + 4) % 32)});
            wr(OFF_EVT_SEL, se);
            rng = xs(rng);
            route(rng, c);
            route(~rng, c);
        end
        $display("test routing done");
        foreach (offs[i]) wr(offs[i], 32'h0);
        levelReq <= 32'h0;
        idle(4);
        wr(OFF_IRQ_STATUS, 32'h000001FF);
        wr(OFF_IRQ_MASK, 32'h0);
        levelReq <= 32'h1;
        idle(5);
        rd(OFF_IRQ_STATUS, 32'h000001FF);
        chkOut({31'h0, irqOut}, 32'h0, "masked irq");
        wr(OFF_IRQ_MASK, 32'h00000001);
        idle(2);
        chkOut({31'h0, irqOut}, 32'h1, "unmasked irq");
        wr(OFF_IRQ_STATUS, 32'h00000001);
        idle(2);
        chkOut({31'h0, irqOut}, 32'h0, "cleared irq");
        rd(OFF_IRQ_STATUS, 32'h000001FE);
        $display("test interrupt done");
        testDone();
    end
endmodule
`default_nettype wire
